// file: pkg/dmem_map_pkg.sv
// Constants for the banked data-memory map of the 8-bit core.
// Assumes a single core clock and a core that issues one data access
// per cycle.
package dmem_map_pkg;

  // Register file offsets (6-bit file address)
  localparam logic [5:0] OFS_INDIRECT_ACCESS_PORT = 6'h00;
  localparam logic [5:0] OFS_TIMER_COUNT          = 6'h01;
  localparam logic [5:0] OFS_PC_LOW_BYTE          = 6'h02;
  localparam logic [5:0] OFS_ALU_RESET_STATUS     = 6'h03;
  localparam logic [5:0] OFS_INDIRECT_POINTER     = 6'h04;
  localparam logic [5:0] OFS_PORT_A_DATA          = 6'h05;
  localparam logic [5:0] OFS_PORT_B_DATA          = 6'h06;
  localparam logic [5:0] OFS_PORT_C_DATA          = 6'h07;
  localparam logic [5:0] OFS_POWER_CONTROL        = 6'h08;
  localparam logic [5:0] OFS_WAKEUP_ENABLE        = 6'h09;
  localparam logic [5:0] OFS_PC_HIGH_BUFFER       = 6'h0a;
  localparam logic [5:0] OFS_PULLDOWN_CONTROL     = 6'h0b;
  localparam logic [5:0] OFS_OPEN_DRAIN_CONTROL   = 6'h0c;
  localparam logic [5:0] OFS_PULLUP_CONTROL       = 6'h0d;
  localparam logic [5:0] OFS_INTERRUPT_ENABLE     = 6'h0e;
  localparam logic [5:0] OFS_INTERRUPT_FLAGS      = 6'h0f;

  // General purpose storage layout
  localparam logic [5:0] GPR_BASE      = 6'h10;
  localparam logic [5:0] MIRROR_TOP    = 6'h2f;
  localparam logic [5:0] BANKED_BASE   = 6'h30;
  localparam int         SHARED_GPRS   = 32;
  localparam int         BANKED_GPRS   = 16;
  localparam int         NUM_BANKS     = 4;
  localparam int         GPR_DEPTH     = SHARED_GPRS + BANKED_GPRS * NUM_BANKS;

  // Pointer field positions
  localparam int         PTR_BANK_HI   = 7;
  localparam int         PTR_BANK_LO   = 6;
  localparam logic [7:0] PTR_BANK_MASK = 8'hc0;

  // Implemented-bit masks; unimplemented positions read as zero
  localparam logic [7:0] MASK_PORT_A      = 8'h0f;
  localparam logic [7:0] MASK_POWER_CTL   = 8'hf0;
  localparam logic [7:0] MASK_INT_ENABLE  = 8'h87;
  localparam logic [7:0] MASK_INT_FLAGS   = 8'h07;
  localparam logic [7:0] MASK_PCH_SMALL   = 8'h01;
  localparam logic [7:0] MASK_PCH_MID     = 8'h03;
  localparam logic [7:0] MASK_PCH_LARGE   = 8'h07;
  // Status: time-out and power-down bits are not writable by the core
  localparam logic [7:0] MASK_STATUS_WR   = 8'he7;

  // Reset values
  localparam logic [7:0] RST_STATUS  = 8'h18;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // Write-only configuration register selectors
  localparam logic [1:0] CFG_TIMER_PRESCALE = 2'h0;
  localparam logic [1:0] CFG_PORT_A_DIR     = 2'h1;
  localparam logic [1:0] CFG_PORT_B_DIR     = 2'h2;
  localparam logic [1:0] CFG_PORT_C_DIR     = 2'h3;
  localparam logic [7:0] MASK_PRESCALE      = 8'h7f;
  localparam logic [7:0] RST_DIR            = 8'hff;
  localparam logic [7:0] RST_PRESCALE       = 8'h7f;

endpackage

// file: hw/banked_data_memory_map.sv
// Data-memory decoder and register file of the 8-bit core: special
// function registers at 00h-0Fh, general purpose storage above them,
// direct and pointer-based indirect access, optional four-bank mode.
// Assumes the core is the only client, on the same clock, and keeps
// its strobes one cycle wide per access.
`timescale 1ns/1ps

module banked_data_memory_map #(
  parameter bit BANKED       = 1'b1, // Largest variant with four banks
  parameter bit HAS_PORT_C   = 1'b1, // Variant with a third port
  parameter int PC_HIGH_BITS = 3     // Implemented PC high buffer bits
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Core data access
  input  wire logic [5:0] acc_addr,
  input  wire logic       acc_rd,
  input  wire logic       acc_wr,
  input  wire logic [7:0] acc_wdata,
  output logic      [7:0] rd_data_q,
  output logic            rd_valid_q,
  // Write-only configuration access
  input  wire logic       cfg_wr,
  input  wire logic [1:0] cfg_sel,
  input  wire logic [7:0] cfg_wdata,
  // Register contents toward peripherals
  output logic      [7:0] indirect_pointer_q,
  output logic      [7:0] pc_high_buffer_q,
  output logic      [7:0] alu_reset_status_q,
  output logic      [7:0] port_c_data_q,
  output logic      [7:0] timer_prescale_config_q,
  output logic      [7:0] port_a_direction_q,
  output logic      [7:0] port_b_direction_q,
  output logic      [7:0] port_c_direction_q
);

  // Implemented bits of the PC high buffer for this variant
  localparam logic [7:0] PCH_MASK =
    (PC_HIGH_BITS >= 3) ? dmem_map_pkg::MASK_PCH_LARGE :
    (PC_HIGH_BITS == 2) ? dmem_map_pkg::MASK_PCH_MID :
                          dmem_map_pkg::MASK_PCH_SMALL;

  // Special function register state
  logic [7:0] timer_count_q,    timer_count_d;
  logic [7:0] pc_low_byte_q,    pc_low_byte_d;
  logic [7:0] status_q,         status_d;
  logic [7:0] pointer_q,        pointer_d;
  logic [7:0] port_a_data_q,    port_a_data_d;
  logic [7:0] port_b_data_q,    port_b_data_d;
  logic [7:0] port_c_q,         port_c_d;
  logic [7:0] power_control_q,  power_control_d;
  logic [7:0] wakeup_enable_q,  wakeup_enable_d;
  logic [7:0] pc_high_q,        pc_high_d;
  logic [7:0] pulldown_q,       pulldown_d;
  logic [7:0] open_drain_q,     open_drain_d;
  logic [7:0] pullup_q,         pullup_d;
  logic [7:0] int_enable_q,     int_enable_d;
  logic [7:0] int_flags_q,      int_flags_d;

  // General purpose storage, flip-flops addressed by index
  logic [7:0] gpr_q [dmem_map_pkg::GPR_DEPTH];
  logic [7:0] gpr_d [dmem_map_pkg::GPR_DEPTH];

  // Write-only configuration state
  logic [7:0] prescale_q, prescale_d;
  logic [7:0] dir_a_q,    dir_a_d;
  logic [7:0] dir_b_q,    dir_b_d;
  logic [7:0] dir_c_q,    dir_c_d;

  // Read answer state
  logic [7:0] rd_data_d;
  logic       rd_valid_d;

  // Decoded access
  logic [5:0] eff_addr;     // Address after indirect resolution
  logic [1:0] bank;         // Bank in force for this access
  logic       self_ind;     // Pointer addresses the indirect port
  logic [7:0] ptr_view;     // Pointer as the core reads it

  // Index into the storage array for a file address and bank. Shared
  // locations land in 0..31; banked ones follow, 16 per bank. With
  // bank forced to zero 10h-3Fh becomes one flat run of 48 bytes.
  function automatic int gpr_index(input logic [5:0] addr,
                                   input logic [1:0] bk);
    int idx;
    idx = int'(addr) - int'(dmem_map_pkg::GPR_BASE);
    if (addr >= dmem_map_pkg::BANKED_BASE)
    begin
      idx = dmem_map_pkg::SHARED_GPRS
          + int'(bk) * dmem_map_pkg::BANKED_GPRS
          + (int'(addr) - int'(dmem_map_pkg::BANKED_BASE));
    end
    return idx;
  endfunction

  // Value the core sees when it reads a file address
  function automatic logic [7:0] read_value(input logic [5:0] addr,
                                            input logic [1:0] bk);
    logic [7:0] v;
    v = dmem_map_pkg::READ_ZERO;
    if (addr == dmem_map_pkg::OFS_INDIRECT_ACCESS_PORT)
      v = dmem_map_pkg::READ_ZERO;
    else if (addr == dmem_map_pkg::OFS_TIMER_COUNT)
      v = timer_count_q;
    else if (addr == dmem_map_pkg::OFS_PC_LOW_BYTE)
      v = pc_low_byte_q;
    else if (addr == dmem_map_pkg::OFS_ALU_RESET_STATUS)
      v = status_q;
    else if (addr == dmem_map_pkg::OFS_INDIRECT_POINTER)
      v = ptr_view;
    else if (addr == dmem_map_pkg::OFS_PORT_A_DATA)
      v = port_a_data_q & dmem_map_pkg::MASK_PORT_A;
    else if (addr == dmem_map_pkg::OFS_PORT_B_DATA)
      v = port_b_data_q;
    else if (addr == dmem_map_pkg::OFS_PORT_C_DATA)
      v = port_c_q;
    else if (addr == dmem_map_pkg::OFS_POWER_CONTROL)
      v = power_control_q & dmem_map_pkg::MASK_POWER_CTL;
    else if (addr == dmem_map_pkg::OFS_WAKEUP_ENABLE)
      v = wakeup_enable_q;
    else if (addr == dmem_map_pkg::OFS_PC_HIGH_BUFFER)
      v = pc_high_q & PCH_MASK;
    else if (addr == dmem_map_pkg::OFS_PULLDOWN_CONTROL)
      v = pulldown_q;
    else if (addr == dmem_map_pkg::OFS_OPEN_DRAIN_CONTROL)
      v = open_drain_q;
    else if (addr == dmem_map_pkg::OFS_PULLUP_CONTROL)
      v = pullup_q;
    else if (addr == dmem_map_pkg::OFS_INTERRUPT_ENABLE)
      v = int_enable_q & dmem_map_pkg::MASK_INT_ENABLE;
    else if (addr == dmem_map_pkg::OFS_INTERRUPT_FLAGS)
      v = int_flags_q & dmem_map_pkg::MASK_INT_FLAGS;
    else
      v = gpr_q[gpr_index(addr, bk)];
    return v;
  endfunction

  // Address resolution: offset 00h means go through the pointer
  always_comb
  begin
    if (acc_addr == dmem_map_pkg::OFS_INDIRECT_ACCESS_PORT)
      eff_addr = pointer_q[5:0];
    else
      eff_addr = acc_addr;
    // Indirect access that lands on the indirect port itself
    self_ind = (acc_addr == dmem_map_pkg::OFS_INDIRECT_ACCESS_PORT) &&
               (pointer_q[5:0] == dmem_map_pkg::OFS_INDIRECT_ACCESS_PORT);
    // Bank bits only count in the banked variant, and below 30h every
    // bank folds onto bank 0
    if (BANKED && (eff_addr >= dmem_map_pkg::BANKED_BASE))
      bank = pointer_q[dmem_map_pkg::PTR_BANK_HI:
                       dmem_map_pkg::PTR_BANK_LO];
    else
      bank = 2'h0;
    // Unused bank bits read as ones on unbanked variants
    if (BANKED)
      ptr_view = pointer_q;
    else
      ptr_view = pointer_q | dmem_map_pkg::PTR_BANK_MASK;
  end

  // Next state of every register the core can write
  always_comb
  begin
    timer_count_d   = timer_count_q;
    pc_low_byte_d   = pc_low_byte_q;
    status_d        = status_q;
    pointer_d       = pointer_q;
    port_a_data_d   = port_a_data_q;
    port_b_data_d   = port_b_data_q;
    port_c_d        = port_c_q;
    power_control_d = power_control_q;
    wakeup_enable_d = wakeup_enable_q;
    pc_high_d       = pc_high_q;
    pulldown_d      = pulldown_q;
    open_drain_d    = open_drain_q;
    pullup_d        = pullup_q;
    int_enable_d    = int_enable_q;
    int_flags_d     = int_flags_q;
    gpr_d           = gpr_q;
    // A self-addressed indirect write changes nothing
    if (acc_wr && !self_ind)
    begin
      if (eff_addr == dmem_map_pkg::OFS_TIMER_COUNT)
        timer_count_d = acc_wdata;
      else if (eff_addr == dmem_map_pkg::OFS_PC_LOW_BYTE)
        pc_low_byte_d = acc_wdata;
      else if (eff_addr == dmem_map_pkg::OFS_ALU_RESET_STATUS)
        // Time-out and power-down flags are owned by reset logic
        status_d = (status_q & ~dmem_map_pkg::MASK_STATUS_WR) |
                   (acc_wdata & dmem_map_pkg::MASK_STATUS_WR);
      else if (eff_addr == dmem_map_pkg::OFS_INDIRECT_POINTER)
      begin
        // Unbanked: bank bits are not stored, so they cannot steer
        if (BANKED)
          pointer_d = acc_wdata;
        else
          pointer_d = acc_wdata & ~dmem_map_pkg::PTR_BANK_MASK;
      end
      else if (eff_addr == dmem_map_pkg::OFS_PORT_A_DATA)
        port_a_data_d = acc_wdata & dmem_map_pkg::MASK_PORT_A;
      else if (eff_addr == dmem_map_pkg::OFS_PORT_B_DATA)
        port_b_data_d = acc_wdata;
      else if (eff_addr == dmem_map_pkg::OFS_PORT_C_DATA)
        port_c_d = acc_wdata;
      else if (eff_addr == dmem_map_pkg::OFS_POWER_CONTROL)
        power_control_d = acc_wdata & dmem_map_pkg::MASK_POWER_CTL;
      else if (eff_addr == dmem_map_pkg::OFS_WAKEUP_ENABLE)
        wakeup_enable_d = acc_wdata;
      else if (eff_addr == dmem_map_pkg::OFS_PC_HIGH_BUFFER)
        pc_high_d = acc_wdata & PCH_MASK;
      else if (eff_addr == dmem_map_pkg::OFS_PULLDOWN_CONTROL)
        pulldown_d = acc_wdata;
      else if (eff_addr == dmem_map_pkg::OFS_OPEN_DRAIN_CONTROL)
        open_drain_d = acc_wdata;
      else if (eff_addr == dmem_map_pkg::OFS_PULLUP_CONTROL)
        pullup_d = acc_wdata;
      else if (eff_addr == dmem_map_pkg::OFS_INTERRUPT_ENABLE)
        int_enable_d = acc_wdata & dmem_map_pkg::MASK_INT_ENABLE;
      else if (eff_addr == dmem_map_pkg::OFS_INTERRUPT_FLAGS)
        int_flags_d = acc_wdata & dmem_map_pkg::MASK_INT_FLAGS;
      else if (eff_addr >= dmem_map_pkg::GPR_BASE)
        gpr_d[gpr_index(eff_addr, bank)] = acc_wdata;
    end
  end

  // Register the special function and storage state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timer_count_q   <= dmem_map_pkg::RST_ZERO;
      pc_low_byte_q   <= dmem_map_pkg::RST_ZERO;
      status_q        <= dmem_map_pkg::RST_STATUS;
      pointer_q       <= dmem_map_pkg::RST_POINTER;
      port_a_data_q   <= dmem_map_pkg::RST_ZERO;
      port_b_data_q   <= dmem_map_pkg::RST_ZERO;
      port_c_q        <= dmem_map_pkg::RST_ZERO;
      power_control_q <= dmem_map_pkg::RST_ZERO;
      wakeup_enable_q <= dmem_map_pkg::RST_ZERO;
      pc_high_q       <= dmem_map_pkg::RST_ZERO;
      pulldown_q      <= dmem_map_pkg::RST_ZERO;
      open_drain_q    <= dmem_map_pkg::RST_ZERO;
      pullup_q        <= dmem_map_pkg::RST_ZERO;
      int_enable_q    <= dmem_map_pkg::RST_ZERO;
      int_flags_q     <= dmem_map_pkg::RST_ZERO;
      for (int i = 0; i < dmem_map_pkg::GPR_DEPTH; i++)
        gpr_q[i] <= dmem_map_pkg::RST_ZERO;
    end
    else
    begin
      timer_count_q   <= timer_count_d;
      pc_low_byte_q   <= pc_low_byte_d;
      status_q        <= status_d;
      pointer_q       <= pointer_d;
      port_a_data_q   <= port_a_data_d;
      port_b_data_q   <= port_b_data_d;
      port_c_q        <= port_c_d;
      power_control_q <= power_control_d;
      wakeup_enable_q <= wakeup_enable_d;
      pc_high_q       <= pc_high_d;
      pulldown_q      <= pulldown_d;
      open_drain_q    <= open_drain_d;
      pullup_q        <= pullup_d;
      int_enable_q    <= int_enable_d;
      int_flags_q     <= int_flags_d;
      gpr_q           <= gpr_d;
    end
  end

  // Read answer: registered, so the core sees data one edge later.
  // A read in the same cycle as a write returns the old contents.
  always_comb
  begin
    rd_valid_d = acc_rd;
    rd_data_d  = rd_data_q;
    if (acc_rd)
      rd_data_d = read_value(eff_addr, bank);
  end

  // Register the read answer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_q  <= dmem_map_pkg::RST_ZERO;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // Write-only configuration registers, reached by their own strobe
  always_comb
  begin
    prescale_d = prescale_q;
    dir_a_d    = dir_a_q;
    dir_b_d    = dir_b_q;
    dir_c_d    = dir_c_q;
    if (cfg_wr)
    begin
      if (cfg_sel == dmem_map_pkg::CFG_TIMER_PRESCALE)
        prescale_d = cfg_wdata & dmem_map_pkg::MASK_PRESCALE;
      else if (cfg_sel == dmem_map_pkg::CFG_PORT_A_DIR)
        dir_a_d = cfg_wdata;
      else if (cfg_sel == dmem_map_pkg::CFG_PORT_B_DIR)
        dir_b_d = cfg_wdata;
      else
        dir_c_d = cfg_wdata;
    end
  end

  // Register the configuration state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prescale_q <= dmem_map_pkg::RST_PRESCALE;
      dir_a_q    <= dmem_map_pkg::RST_DIR;
      dir_b_q    <= dmem_map_pkg::RST_DIR;
      dir_c_q    <= dmem_map_pkg::RST_DIR;
    end
    else
    begin
      prescale_q <= prescale_d;
      dir_a_q    <= dir_a_d;
      dir_b_q    <= dir_b_d;
      dir_c_q    <= dir_c_d;
    end
  end

  // Outputs straight from flip-flops. Without a third port location
  // 07h is still stored, but port_c_data_q is held at zero.
  assign indirect_pointer_q      = pointer_q;
  assign pc_high_buffer_q        = pc_high_q;
  assign alu_reset_status_q      = status_q;
  assign port_c_data_q           = HAS_PORT_C ? port_c_q
                                              : dmem_map_pkg::RST_ZERO;
  assign timer_prescale_config_q = prescale_q;
  assign port_a_direction_q      = dir_a_q;
  assign port_b_direction_q      = dir_b_q;
  assign port_c_direction_q      = dir_c_q;

endmodule

// file: testbench/dmem_map_assertions.sv
// Checker for the banked data-memory register file ports.
// Assumes one core clock and the async active-low reset.
`timescale 1ns/1ps

module dmem_map_checker #(
  parameter bit BANKED       = 1'b1,
  parameter bit HAS_PORT_C   = 1'b1,
  parameter int PC_HIGH_BITS = 3
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Core and config access
  input wire logic [5:0] acc_addr,
  input wire logic       acc_rd,
  input wire logic       acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] rd_data_q,
  input wire logic       rd_valid_q,
  input wire logic       cfg_wr,
  input wire logic [1:0] cfg_sel,
  input wire logic [7:0] cfg_wdata,
  // Register contents
  input wire logic [7:0] indirect_pointer_q,
  input wire logic [7:0] pc_high_buffer_q,
  input wire logic [7:0] alu_reset_status_q,
  input wire logic [7:0] port_c_data_q,
  input wire logic [7:0] timer_prescale_config_q
);
  // Implemented PC high bits for this variant
  localparam logic [7:0] PCH_MASK = 8'((1 << PC_HIGH_BITS) - 1);
  // Location of the indirect port and the pointer
  localparam logic [5:0] A_IND = 6'h00;
  localparam logic [5:0] A_PTR = 6'h04;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // The answer rises in the cycle after the strobe, so the check
  // starts where the antecedent ends
  rd_pulse_a: assert property (acc_rd ##1 !acc_rd |->
      rd_valid_q ##1 !rd_valid_q)
    else $error("read valid not a one-cycle answer");
  quiet_valid_a: assert property (!acc_rd |=>
      !rd_valid_q && $stable(rd_data_q))
    else $error("read data moved without a read");
  self_read_a: assert property (acc_rd && acc_addr == A_IND &&
      indirect_pointer_q[5:0] == A_IND |=> rd_data_q == 8'h00)
    else $error("self indirect read not zero");
  self_write_a: assert property (acc_wr && acc_addr == A_IND &&
      indirect_pointer_q[5:0] == A_IND |=> $stable(indirect_pointer_q) &&
      $stable(pc_high_buffer_q) && $stable(port_c_data_q))
    else $error("self indirect write changed a register");
  ptr_bits_a: assert property (acc_rd && acc_addr == A_PTR |=>
      rd_data_q[5:0] == $past(indirect_pointer_q[5:0]) &&
      (BANKED || rd_data_q[7:6] == 2'b11))
    else $error("pointer read back wrong");
  // Unbanked variants must not keep the bank bits at all
  ptr_write_a: assert property (acc_wr && acc_addr == A_PTR |=>
      indirect_pointer_q[5:0] == $past(acc_wdata[5:0]) &&
      (BANKED ? indirect_pointer_q[7:6] == $past(acc_wdata[7:6])
              : indirect_pointer_q[7:6] == 2'b00))
    else $error("pointer write not stored");
  port_c_data_a: assert property (acc_wr && acc_addr == 6'h07 |=>
      port_c_data_q == (HAS_PORT_C ? $past(acc_wdata) : 8'h00))
    else $error("third port data wrong");
  pch_write_a: assert property (acc_wr && acc_addr == 6'h0a |=>
      pc_high_buffer_q == ($past(acc_wdata) & PCH_MASK))
    else $error("pc high buffer width wrong");
  prescale_msb_a: assert property (cfg_wr && cfg_sel == 2'h0 |=>
      timer_prescale_config_q == ($past(cfg_wdata) & 8'h7f))
    else $error("prescale unimplemented bit not zero");
  // Time-out and power-down flags belong to reset logic, never the core
  status_keep_a: assert property ($stable(alu_reset_status_q[4:3]))
    else $error("status reset flags changed");

  // Main scenarios seen
  self_c: cover property (acc_rd && acc_addr == A_IND && indirect_pointer_q[5:0] == A_IND);
  bank3_c: cover property (acc_rd && indirect_pointer_q[7:6] == 2'b11);
  pch_c: cover property (acc_wr && acc_addr == 6'h0a);
endmodule

bind banked_data_memory_map dmem_map_checker #(.BANKED(BANKED),
  .HAS_PORT_C(HAS_PORT_C), .PC_HIGH_BITS(PC_HIGH_BITS)) chk (
  .clk(clk), .arst_n(arst_n), .acc_addr(acc_addr), .acc_rd(acc_rd),
  .acc_wr(acc_wr), .acc_wdata(acc_wdata), .rd_data_q(rd_data_q),
  .rd_valid_q(rd_valid_q), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
  .cfg_wdata(cfg_wdata), .indirect_pointer_q(indirect_pointer_q),
  .pc_high_buffer_q(pc_high_buffer_q),
  .alu_reset_status_q(alu_reset_status_q),
  .port_c_data_q(port_c_data_q),
  .timer_prescale_config_q(timer_prescale_config_q));

// file: testbench/core_access_model.sv
// Model of the processor core issuing single data accesses.
// Assumes strobes are taken on the rising edge after they rise.
`timescale 1ns/1ps

module core_access_model (
  // Clock
  input  wire logic       clk,
  // Access lines toward the register file
  output logic      [5:0] acc_addr,
  output logic            acc_rd,
  output logic            acc_wr,
  output logic      [7:0] acc_wdata
);
  initial
  begin
    acc_addr = 6'h3f;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_wdata = 8'h00;
  end

  // One access held for exactly one taking edge, then idle gap cycles
  task automatic access(input logic rd, input logic wr, input logic [5:0] a,
                        input logic [7:0] d, input int gap);
    @(posedge clk);
    #1;
    acc_addr = a;
    acc_wdata = d;
    acc_rd = rd;
    acc_wr = wr;
    @(posedge clk);
    #1;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    // Released lines flip so a stale value never looks valid
    acc_addr = ~a;
    acc_wdata = ~d;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench: a banked and an unbanked register file share
// one core model; read answers are matched against queued notes.
`timescale 1ns/1ps

module tb_top;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [5:0] acc_addr;
  logic       acc_rd, acc_wr, vb, vs;
  logic [7:0] acc_wdata, rdb, rds, pchb, pchs, pcb, pcs;
  logic       cfg_wr = 1'b0;
  logic [1:0] cfg_sel = 2'h0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] pre, dira, dirb, dirc;
  logic [7:0] q_big[$], q_small[$];
  logic [31:0] seed = 32'd96;
  int         err_total = 0;
  int         tests_run = 0;

  // Clock at 10 MHz
  always #50 clk = ~clk;

  core_access_model core (.clk(clk), .acc_addr(acc_addr), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .acc_wdata(acc_wdata));

  banked_data_memory_map DUT (.clk(clk), .arst_n(arst_n),
    .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .rd_data_q(rdb), .rd_valid_q(vb),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
    .indirect_pointer_q(), .pc_high_buffer_q(pchb),
    .alu_reset_status_q(), .port_c_data_q(pcb),
    .timer_prescale_config_q(pre), .port_a_direction_q(dira),
    .port_b_direction_q(dirb), .port_c_direction_q(dirc));

  // Smallest variant: no banks, no third port, one PC high bit
  banked_data_memory_map #(.BANKED(1'b0), .HAS_PORT_C(1'b0),
    .PC_HIGH_BITS(1)) dut_small (.clk(clk), .arst_n(arst_n),
    .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .rd_data_q(rds), .rd_valid_q(vs),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
    .indirect_pointer_q(), .pc_high_buffer_q(pchs),
    .alu_reset_status_q(), .port_c_data_q(pcs),
    .timer_prescale_config_q(), .port_a_direction_q(),
    .port_b_direction_q(), .port_c_direction_q());

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Writes come with a random idle gap, so the core is quick or slow
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    core.access(1'b0, 1'b1, a, d, int'(rnd() % 2));
  endtask

  // Reads note both expectations before the strobe goes out
  task automatic rd(input logic [5:0] a, input logic [7:0] eb,
                    input logic [7:0] es);
    q_big.push_back(eb);
    q_small.push_back(es);
    core.access(1'b1, 1'b0, a, 8'h00, 0);
  endtask

  task automatic print_verdict();
    $display("counts: tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Answers are matched against the oldest note once settled
  always @(posedge clk)
  begin
    #2;
    if (vb === 1'b1)
      check("rd_big", rdb,
            (q_big.size() > 0) ? q_big.pop_front() : 8'hxx);
    if (vs === 1'b1)
      check("rd_small", rds,
            (q_small.size() > 0) ? q_small.pop_front() : 8'hxx);
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  // Register, expected big, expected small after writing ff
  localparam logic [5:0] MA [8] = '{6'h05, 6'h08, 6'h0e, 6'h0f, 6'h0a,
                                    6'h01, 6'h04, 6'h03};
  localparam logic [7:0] EB [8] = '{8'h0f, 8'hf0, 8'h87, 8'h07, 8'h07,
                                    8'hff, 8'hff, 8'hff};
  localparam logic [7:0] ES [8] = '{8'h0f, 8'hf0, 8'h87, 8'h07, 8'h01,
                                    8'hff, 8'hff, 8'hff};

  initial
  begin
    logic [31:0] r;
    logic [5:0]  a;
    logic [7:0]  d;
    logic [7:0]  cv [4];
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    rd(6'h03, 8'h18, 8'h18);
    rd(6'h04, 8'h00, 8'hc0);
    check("prescale", pre, 8'h7f);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      wr(MA[i], 8'hff);
      rd(MA[i], EB[i], ES[i]);
    end
    check("pch_big", pchb, 8'h07);
    check("pch_small", pchs, 8'h01);
    // Clearing status must leave the reset-owned flags set
    wr(6'h03, 8'h00);
    rd(6'h03, 8'h18, 8'h18);
    $display("test masks done");
    for (int b = 0; b < 4; b++)
    begin
      wr(6'h04, {b[1:0], 6'h30});
      wr(6'h30, 8'(8'h40 + b));
      wr(6'h20, 8'(8'h50 + b));
    end
    for (int b = 0; b < 4; b++)
    begin
      wr(6'h04, {b[1:0], 6'h30});
      rd(6'h30, 8'(8'h40 + b), 8'h43);
      rd(6'h00, 8'(8'h40 + b), 8'h43);
      rd(6'h20, 8'h53, 8'h53);
    end
    $display("test banks done");
    wr(6'h04, 8'h00);
    wr(6'h00, 8'h55);
    rd(6'h00, 8'h00, 8'h00);
    rd(6'h04, 8'h00, 8'hc0);
    wr(6'h07, 8'ha5);
    check("port_c_big", pcb, 8'ha5);
    check("port_c_small", pcs, 8'h00);
    rd(6'h07, 8'ha5, 8'ha5);
    $display("test indirect self and port c done");
    // Mid-run reset: registers fall back to their reset values
    @(posedge clk);
    #1 arst_n = 1'b0;
    @(posedge clk);
    #1 arst_n = 1'b1;
    check("pch_reset", pchb, 8'h00);
    check("port_c_reset", pcb, 8'h00);
    rd(6'h04, 8'h00, 8'hc0);
    $display("test mid reset done");
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      a = 6'h10 + {1'b0, r[4:0]};
      d = r[15:8];
      wr(6'h04, {r[7:6], a});
      wr(6'h00, d);
      rd(a, d, d);
    end
    $display("test random storage done");
    for (int s = 0; s < 4; s++)
    begin
      cv[s] = 8'(rnd() >> 8);
      @(posedge clk);
      #1;
      cfg_wr = 1'b1;
      cfg_sel = s[1:0];
      cfg_wdata = cv[s];
      @(posedge clk);
      #1 cfg_wr = 1'b0;
    end
    check("prescale", pre, cv[0] & 8'h7f);
    check("dir_a", dira, cv[1]);
    check("dir_b", dirb, cv[2]);
    check("dir_c", dirc, cv[3]);
    $display("test config done");
    for (int i = 0; i < 10 && q_big.size() + q_small.size() > 0; i++)
      @(posedge clk);
    if (q_big.size() + q_small.size() > 0)
      err_total++;
    print_verdict();
  end
endmodule
